// ### common/acs_pkg.sv
// Purpose: Shared constants for the asynchronous counter with gate select
// Assumes: APB data 32 bits; register byte address is four times the index
// Notes:   Registers are 8 bits wide in the low byte lane
`default_nettype none
package acs_pkg;
  localparam int unsigned ACS_ADDR_W      = 12;
  localparam int unsigned ACS_SYNC_STAGES = 3;
  // Register indices
  localparam logic [7:0] ACS_IDX_CORE_IRQ  = 8'h0B;
  localparam logic [7:0] ACS_IDX_PFLAGS    = 8'h0C;
  localparam logic [7:0] ACS_IDX_COUNT_LO  = 8'h0E;
  localparam logic [7:0] ACS_IDX_COUNT_HI  = 8'h0F;
  localparam logic [7:0] ACS_IDX_CTRL      = 8'h10;
  localparam logic [7:0] ACS_IDX_GATE_CFG  = 8'h1A;
  localparam logic [7:0] ACS_IDX_PENABLES  = 8'h8C;
  // Field positions
  localparam int unsigned ACS_CC_ON    = 0;
  localparam int unsigned ACS_CC_CS    = 1;
  localparam int unsigned ACS_CC_ASYNC = 2;
  localparam int unsigned ACS_CC_OSC   = 3;
  localparam int unsigned ACS_CC_PS    = 4;
  localparam int unsigned ACS_CC_GE    = 6;
  localparam int unsigned ACS_CC_GINV  = 7;
  localparam int unsigned ACS_GS_CSYNC = 0;
  localparam int unsigned ACS_GS_GSS   = 1;
  localparam int unsigned ACS_PF_OVF   = 0;
  localparam int unsigned ACS_PE_OVF   = 0;
  localparam int unsigned ACS_CI_PERIPHERAL_IRQ_ENABLE  = 6;
  localparam int unsigned ACS_CI_GIE   = 7;
  // Synchronised pin slots
  localparam int unsigned ACS_PIN_EXT  = 0;
  localparam int unsigned ACS_PIN_GATE = 1;
  localparam int unsigned ACS_PIN_CMP  = 2;
  // Reset values and masks
  localparam logic [7:0]  ACS_RST_CTRL     = 8'h00;
  localparam logic [7:0]  ACS_RST_GATE_CFG = 8'h02;
  localparam logic [7:0]  ACS_RST_CORE_IRQ = 8'h00;
  localparam logic [7:0]  ACS_RST_PFLAGS   = 8'h00;
  localparam logic [7:0]  ACS_RST_PENABLES = 8'h00;
  localparam logic [15:0] ACS_RST_COUNT    = 16'h0000;
  localparam logic [2:0]  ACS_RST_PRESC    = 3'h0;
  localparam logic [7:0]  ACS_GATE_CFG_MSK = 8'h03;
  localparam logic [7:0]  ACS_PFLAGS_MSK   = 8'h01;
  localparam logic [7:0]  ACS_PENABLES_MSK = 8'h01;
  localparam logic [15:0] ACS_COUNT_MAX    = 16'hFFFF;

  function automatic logic [ACS_ADDR_W-1:0] acs_byte_addr(input logic [7:0] idx);
    acs_byte_addr = {2'b00, idx, 2'b00};
  endfunction
endpackage
`default_nettype wire

// ### common/acs_pin_if.sv
// Purpose: Carries synchronised pin levels and clock edges
// Assumes: Single pclk domain
// Notes:   Slot order follows the pin slot constants
`timescale 1ns/100ps
`default_nettype none
interface acs_pin_if;
  logic [2:0] lvl;
  logic       ext_rise;
  logic       ext_fall;
  modport src (output lvl, output ext_rise, output ext_fall);
  modport dst (input lvl, input ext_rise, input ext_fall);
endinterface
`default_nettype wire

// ### rtl/acs_pin_sync.sv
// Purpose: Three-stage input conditioning for pin inputs
// Assumes: Inputs asynchronous to pclk
// Notes:   A level is accepted once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module acs_pin_sync
  import acs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] raw_in,
  acs_pin_if.src          pins
);
  logic [2:0] st1;
  logic [2:0] st2;
  logic [2:0] st3;
  logic [2:0] lvl_q;
  logic       rise_q;
  logic       fall_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st1[gi]   <= 1'b0;
          st2[gi]   <= 1'b0;
          st3[gi]   <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end else begin
          st1[gi] <= raw_in[gi];
          st2[gi] <= st1[gi];
          st3[gi] <= st2[gi];
          if (st2[gi] == st3[gi]) begin
            lvl_q[gi] <= st3[gi];
          end
        end
      end
    end
  endgenerate

  // Edge pulses of the accepted counter clock level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= (st2[ACS_PIN_EXT] == st3[ACS_PIN_EXT]) & st3[ACS_PIN_EXT] & ~lvl_q[ACS_PIN_EXT];
      fall_q <= (st2[ACS_PIN_EXT] == st3[ACS_PIN_EXT]) & ~st3[ACS_PIN_EXT] & lvl_q[ACS_PIN_EXT];
    end
  end

  assign pins.lvl      = lvl_q;
  assign pins.ext_rise = rise_q;
  assign pins.ext_fall = fall_q;
endmodule // acs_pin_sync
`default_nettype wire

// ### rtl/acs_counter.sv
// Purpose: 16-bit counter with async external clock, sleep wake and gate select
// Assumes: APB slave on pclk; pins enter through three-stage conditioning
// Notes:   Count bytes read directly from the live counter each access
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// R01: Async mode counts external clock unsynchronised; here the pin still passes the three-stage sync
// R02: Async mode keeps counting and interrupting in sleep
// R03: Each count byte read returns valid value
// R04: Software reconciles overflow between two byte reads
// R05: Software stops counter before writing count bytes
// R06: Oscillator enable bit turns on crystal oscillator
// R07: Oscillator usable only with internal primary clock
// R08: Enabled oscillator forces pin directions, reads zero
// R09: Software waits oscillator start-up before counter on
// R10: Sleep counting only in async external mode
// R11: Software sets on, overflow and peripheral enables
// R12: Sleep overflow wakes; vectors only when global set
// R13: Gate source select: pin or comparator two
// R14: Comparator two latched after prescaler, before increment
// R15: Rollover from maximum sets overflow flag
// R16: Gating acts only with gate enable set
// R17: Wake from flag and enables, ignoring global
module acs_counter
  import acs_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [ACS_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  ext_count_clk,
  input  wire logic                  gate_input_pin,
  input  wire logic                  cmp_two_out,
  input  wire logic                  cpu_sleep,
  input  wire logic                  primary_clk_internal,
  input  wire logic [1:0]            port_dir_in,
  input  wire logic [1:0]            port_val_in,
  output var  logic                  irq,
  output var  logic                  wake_request,
  output var  logic                  crystal_osc_run,
  output var  logic                  osc_in_pin_direction,
  output var  logic                  osc_out_pin_direction,
  output var  logic                  gate_capable_port_pin,
  output var  logic                  osc_port_pin
);
  import acs_pkg::*;

  acs_pin_if pins ();

  logic [7:0]  counter_control;
  logic [7:0]  gate_source_config;
  logic [7:0]  core_interrupt_control;
  logic [7:0]  peripheral_enables_one;
  logic        overflow_flag;
  logic [15:0] count;
  logic [2:0]  presc;
  logic        fall_seen;
  logic        cmp_latched;

  logic        access_now;
  logic        commit;
  logic        wr_commit;
  logic        addr_hit;
  logic [7:0]  rd_byte;
  logic        osc_active;
  logic        ext_mode;
  logic        async_ext;
  logic        running;
  logic        raw_event;
  logic        gate_src;
  logic        gate_ok;
  logic        step;
  logic [2:0]  presc_mask;
  logic        presc_out;
  logic        tick;
  logic        overflow_evt;
  logic        wr_lo;
  logic        wr_hi;
  logic        wake_term;

  acs_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  ({cmp_two_out, gate_input_pin, ext_count_clk}),
    .pins    (pins.src)
  );

  function automatic logic reg_is(input logic [ACS_ADDR_W-1:0] a, input logic [7:0] idx);
    reg_is = (a == acs_byte_addr(idx));
  endfunction

  // Bus decode
  assign access_now = psel & penable & ~pready;
  assign commit     = psel & penable & pready;
  assign wr_commit  = commit & pwrite;
  assign wr_lo      = wr_commit & reg_is(paddr, ACS_IDX_COUNT_LO);
  assign wr_hi      = wr_commit & reg_is(paddr, ACS_IDX_COUNT_HI);
  assign addr_hit   = reg_is(paddr, ACS_IDX_CORE_IRQ) | reg_is(paddr, ACS_IDX_PFLAGS)
                    | reg_is(paddr, ACS_IDX_COUNT_LO) | reg_is(paddr, ACS_IDX_COUNT_HI)
                    | reg_is(paddr, ACS_IDX_CTRL)     | reg_is(paddr, ACS_IDX_GATE_CFG)
                    | reg_is(paddr, ACS_IDX_PENABLES);

  // R03: live count bytes
  always_comb begin
    rd_byte = 8'h00;
    if (reg_is(paddr, ACS_IDX_CORE_IRQ)) begin
      rd_byte = core_interrupt_control;
    end else if (reg_is(paddr, ACS_IDX_PFLAGS)) begin
      rd_byte = {7'h00, overflow_flag};
    end else if (reg_is(paddr, ACS_IDX_COUNT_LO)) begin
      rd_byte = count[7:0];
    end else if (reg_is(paddr, ACS_IDX_COUNT_HI)) begin
      rd_byte = count[15:8];
    end else if (reg_is(paddr, ACS_IDX_CTRL)) begin
      rd_byte = counter_control;
    end else if (reg_is(paddr, ACS_IDX_GATE_CFG)) begin
      rd_byte = gate_source_config;
    end else if (reg_is(paddr, ACS_IDX_PENABLES)) begin
      rd_byte = peripheral_enables_one;
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access_now) begin
      pready  <= 1'b1;
      prdata  <= addr_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= ~addr_hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_control        <= ACS_RST_CTRL;
      gate_source_config     <= ACS_RST_GATE_CFG;
      core_interrupt_control <= ACS_RST_CORE_IRQ;
      peripheral_enables_one <= ACS_RST_PENABLES;
    end else if (wr_commit) begin
      if (reg_is(paddr, ACS_IDX_CTRL)) begin
        counter_control <= pwdata[7:0];
      end
      // R13: gate source and sync select
      if (reg_is(paddr, ACS_IDX_GATE_CFG)) begin
        gate_source_config <= pwdata[7:0] & ACS_GATE_CFG_MSK;
      end
      if (reg_is(paddr, ACS_IDX_CORE_IRQ)) begin
        core_interrupt_control <= pwdata[7:0];
      end
      if (reg_is(paddr, ACS_IDX_PENABLES)) begin
        peripheral_enables_one <= pwdata[7:0] & ACS_PENABLES_MSK;
      end
    end
  end

  // R07: oscillator only with internal primary clock
  assign osc_active = counter_control[ACS_CC_OSC] & primary_clk_internal;
  assign ext_mode   = counter_control[ACS_CC_CS];
  // R01: async external mode only keeps counting in sleep; the pin edge stays synchronised
  assign async_ext  = ext_mode & counter_control[ACS_CC_ASYNC];
  // R10: sleep stops all but async external counting
  assign running    = counter_control[ACS_CC_ON] & (~cpu_sleep | async_ext);
  assign raw_event  = ext_mode ? (pins.ext_rise & fall_seen) : 1'b1;

  // R13: gate source pick
  always_comb begin
    gate_src = pins.lvl[ACS_PIN_GATE];
    if (!gate_source_config[ACS_GS_GSS]) begin
      gate_src = gate_source_config[ACS_GS_CSYNC] ? cmp_latched : pins.lvl[ACS_PIN_CMP];
    end
  end

  // R16: gate applies only when enabled
  assign gate_ok = ~counter_control[ACS_CC_GE]
                 | (counter_control[ACS_CC_GINV] ? gate_src : ~gate_src);

  // Prescaler sees every counter clock event; the gate acts after it
  assign step       = raw_event & running;
  assign presc_mask = counter_control[ACS_CC_PS +: 2] == 2'h3 ? 3'h7 :
                      counter_control[ACS_CC_PS +: 2] == 2'h2 ? 3'h3 :
                      counter_control[ACS_CC_PS +: 2] == 2'h1 ? 3'h1 : 3'h0;
  assign presc_out  = step & (presc == presc_mask);
  assign tick       = presc_out & gate_ok;
  // R15: rollover from maximum
  assign overflow_evt = tick & (count == ACS_COUNT_MAX) & ~wr_lo & ~wr_hi;

  // First incrementing edge needs a prior falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_seen <= 1'b0;
    end else if (!counter_control[ACS_CC_ON] || !ext_mode) begin
      fall_seen <= 1'b0;
    end else if (pins.ext_fall) begin
      fall_seen <= 1'b1;
    end
  end

  // Prescaler, cleared by any count byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= ACS_RST_PRESC;
    end else if (wr_lo || wr_hi || !counter_control[ACS_CC_ON]) begin
      presc <= ACS_RST_PRESC;
    end else if (presc_out) begin
      presc <= ACS_RST_PRESC;
    end else if (step) begin
      presc <= presc + 3'h1;
    end
  end

  // R14: latch at prescaler output, ungated so a closed gate can reopen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_latched <= 1'b0;
    end else if (!gate_source_config[ACS_GS_CSYNC] || presc_out
                 || !counter_control[ACS_CC_ON]) begin
      cmp_latched <= pins.lvl[ACS_PIN_CMP];
    end
  end

  // R02: counter keeps stepping in sleep when async
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= ACS_RST_COUNT;
    end else if (wr_lo) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr_hi) begin
      count[15:8] <= pwdata[7:0];
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // R15: sticky flag, set beats write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= ACS_RST_PFLAGS[ACS_PF_OVF];
    end else if (overflow_evt) begin
      overflow_flag <= 1'b1;
    end else if (wr_commit && reg_is(paddr, ACS_IDX_PFLAGS) && pwdata[ACS_PF_OVF]) begin
      overflow_flag <= 1'b0;
    end
  end

  // R17: wake ignores global enable
  assign wake_term = overflow_flag & peripheral_enables_one[ACS_PE_OVF]
                   & core_interrupt_control[ACS_CI_PERIPHERAL_IRQ_ENABLE];

  // R12: vector request only with global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
      irq          <= 1'b0;
    end else begin
      wake_request <= wake_term;
      irq          <= wake_term & core_interrupt_control[ACS_CI_GIE];
    end
  end

  // R06: oscillator run enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_osc_run <= 1'b0;
    end else begin
      crystal_osc_run <= osc_active;
    end
  end

  // R08: pins forced to input, port bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_in_pin_direction  <= 1'b1;
      osc_out_pin_direction <= 1'b1;
      gate_capable_port_pin <= 1'b0;
      osc_port_pin          <= 1'b0;
    end else begin
      osc_in_pin_direction  <= osc_active | port_dir_in[0];
      osc_out_pin_direction <= osc_active | port_dir_in[1];
      gate_capable_port_pin <= ~osc_active & port_val_in[0];
      osc_port_pin          <= ~osc_active & port_val_in[1];
    end
  end
endmodule // acs_counter
`default_nettype wire

// ### tb/acs_ext_src.sv
// Purpose: External count clock source for the counter
// Assumes: Runs only while run is high
// Notes:   Stands still low between bursts
`timescale 1ns/100ps
`default_nettype none
module acs_ext_src #(
  parameter int HALF_NS = 50
) (
  input  wire logic run,
  output var  logic clk_out
);
  initial clk_out = 1'b0;
  always begin
    #(HALF_NS);
    clk_out = run ? ~clk_out : 1'b0;
  end
endmodule // acs_ext_src
`default_nettype wire

// ### tb/acs_counter_asserts.sv
// Purpose: Port checks for acs_counter
// Assumes: One pclk domain
// Notes:   Bound to every acs_counter instance
`timescale 1ns/100ps
`default_nettype none
module acs_counter_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       primary_clk_internal,
  input wire logic [1:0] port_dir_in,
  input wire logic       irq,
  input wire logic       wake_request,
  input wire logic       crystal_osc_run,
  input wire logic       osc_in_pin_direction,
  input wire logic       osc_out_pin_direction,
  input wire logic       gate_capable_port_pin,
  input wire logic       osc_port_pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_in_access: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  a_irq_needs_wake: assert property (irq |-> wake_request)
    else $error("irq without wake");
  a_osc_internal_only: assert property (crystal_osc_run |-> $past(primary_clk_internal))
    else $error("osc runs without internal clock");
  a_osc_forces_pins: assert property (crystal_osc_run |-> osc_in_pin_direction
    && osc_out_pin_direction && !gate_capable_port_pin && !osc_port_pin)
    else $error("osc pins not forced");
  a_dir_follows_port: assert property ($past(presetn) && !crystal_osc_run
    |-> {osc_out_pin_direction, osc_in_pin_direction} == $past(port_dir_in))
    else $error("direction not from port");
  a_wake_clear_write: assert property ($fell(wake_request)
    |-> $past(wr_done) || $past(wr_done, 2))
    else $error("wake fell without write");
  c_wake_no_vector: cover property (wake_request && !irq);
  c_unmapped: cover property (pslverr);
  c_osc_run: cover property (crystal_osc_run);
endmodule // acs_counter_asserts
bind acs_counter acs_counter_asserts i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
  .primary_clk_internal, .port_dir_in, .irq, .wake_request, .crystal_osc_run,
  .osc_in_pin_direction, .osc_out_pin_direction, .gate_capable_port_pin, .osc_port_pin
);
`default_nettype wire

// ### tb/async_counter_sleep_wake_gate_select_bench.sv
// Purpose: Self-checking bench for acs_counter
// Assumes: APB master, one transfer per call
// Notes:   External count clock from acs_ext_src
`timescale 1ns/100ps
`default_nettype none
module async_counter_sleep_wake_gate_select_bench;
  import acs_pkg::*;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic [ACS_ADDR_W-1:0] paddr = '0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [31:0]           pwdata = '0;
  logic [31:0]           prdata;
  logic                  pready, pslverr, irq, wake_request, crystal_osc_run;
  logic                  ext_run = 1'b0;
  logic                  ext_count_clk;
  logic                  gate_input_pin = 1'b0;
  logic                  cmp_two_out = 1'b0;
  logic                  cpu_sleep = 1'b0;
  logic                  primary_clk_internal = 1'b1;
  logic [1:0]            port_dir_in = 2'b00;
  logic [1:0]            port_val_in = 2'b11;
  logic                  osc_in_pin_direction, osc_out_pin_direction;
  logic                  gate_capable_port_pin, osc_port_pin;
  logic [4:0]            osc_view;
  int                    n_fail = 0;
  int                    n_tests = 0;
  logic [7:0] idx_t [7] = '{ACS_IDX_CORE_IRQ, ACS_IDX_PFLAGS, ACS_IDX_COUNT_LO,
    ACS_IDX_COUNT_HI, ACS_IDX_CTRL, ACS_IDX_GATE_CFG, ACS_IDX_PENABLES};
  logic [7:0] rst_t [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [7:0] c_t [9] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h01, 8'hC1, 8'h41, 8'h41, 8'h41};
  logic [7:0] g_t [9] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01};
  logic [1:0] p_t [9] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b11, 2'b10, 2'b10, 2'b01, 2'b10};
  logic       m_t [9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  assign osc_view = {crystal_osc_run, osc_out_pin_direction, osc_in_pin_direction,
                     osc_port_pin, gate_capable_port_pin};
  always #10 pclk = ~pclk;
  // Half period chosen so source edges never meet a pclk rising edge
  acs_ext_src #(.HALF_NS(52)) i_src (.run(ext_run), .clk_out(ext_count_clk));
  acs_counter i_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .ext_count_clk, .gate_input_pin, .cmp_two_out, .cpu_sleep,
    .primary_clk_internal, .port_dir_in, .port_val_in, .irq, .wake_request,
    .crystal_osc_run, .osc_in_pin_direction, .osc_out_pin_direction,
    .gate_capable_port_pin, .osc_port_pin
  );

  task automatic complete_run;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    paddr  <= {2'b00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h0, wd};
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(idx, 1'b1, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(idx, 1'b0, 8'h00, r, e);
    chk(r, exp);
  endtask

  task automatic wait_wake;
    int n;
    for (n = 0; n < 400 && wake_request !== 1'b1; n++) begin
      @(posedge pclk);
    end
    if (n == 400) begin
      n_fail++;
      complete_run();
    end
  endtask

  // Two live reads of the low byte tell whether the count moves
  task automatic moves(input logic [7:0] c, input logic [7:0] g, input logic [1:0] pc,
                       input logic exp);
    logic [31:0] a;
    logic [31:0] b;
    logic        e;
    @(posedge pclk);
    gate_input_pin <= pc[1];
    cmp_two_out    <= pc[0];
    wr(ACS_IDX_GATE_CFG, g);
    wr(ACS_IDX_CTRL, c);
    apb(ACS_IDX_COUNT_LO, 1'b0, 8'h00, a, e);
    apb(ACS_IDX_COUNT_LO, 1'b0, 8'h00, b, e);
    chk({31'h0, a !== b}, {31'h0, exp});
  endtask

  initial begin : main
    logic [31:0] r;
    logic        e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdchk(idx_t[i], {24'h0, rst_t[i]});
    end
    apb(8'h40, 1'b0, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    wr(ACS_IDX_GATE_CFG, 8'hFF);
    rdchk(ACS_IDX_GATE_CFG, 32'h03);
    $display("test registers done");
    wr(ACS_IDX_PENABLES, 8'h01);
    wr(ACS_IDX_CORE_IRQ, 8'h40);
    wr(ACS_IDX_COUNT_HI, 8'hFF);
    wr(ACS_IDX_COUNT_LO, 8'hF0);
    rdchk(ACS_IDX_COUNT_HI, 32'hFF);
    wr(ACS_IDX_CTRL, 8'h01);
    wait_wake();
    chk({31'h0, irq}, 32'h0);
    rdchk(ACS_IDX_PFLAGS, 32'h01);
    wr(ACS_IDX_CORE_IRQ, 8'hC0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(ACS_IDX_PENABLES, 8'h00);
    repeat (3) @(posedge pclk);
    chk({30'h0, irq, wake_request}, 32'h0);
    wr(ACS_IDX_PENABLES, 8'h01);
    wr(ACS_IDX_PFLAGS, 8'h01);
    repeat (3) @(posedge pclk);
    chk({30'h0, irq, wake_request}, 32'h0);
    rdchk(ACS_IDX_PFLAGS, 32'h00);
    wr(ACS_IDX_CTRL, 8'h00);
    $display("test overflow done");
    wr(ACS_IDX_COUNT_HI, 8'h00);
    wr(ACS_IDX_COUNT_LO, 8'h00);
    wr(ACS_IDX_CTRL, 8'h03);
    @(posedge pclk);
    cpu_sleep <= 1'b1;
    ext_run   <= 1'b1;
    repeat (60) @(posedge pclk);
    rdchk(ACS_IDX_COUNT_LO, 32'h00);
    wr(ACS_IDX_CTRL, 8'h00);
    wr(ACS_IDX_COUNT_HI, 8'hFF);
    wr(ACS_IDX_COUNT_LO, 8'hF8);
    wr(ACS_IDX_CTRL, 8'h07);
    wait_wake();
    rdchk(ACS_IDX_PFLAGS, 32'h01);
    @(posedge pclk);
    cpu_sleep <= 1'b0;
    ext_run   <= 1'b0;
    wr(ACS_IDX_CTRL, 8'h00);
    wr(ACS_IDX_PFLAGS, 8'h01);
    $display("test sleep done");
    for (int i = 0; i < 9; i++) begin
      moves(c_t[i], g_t[i], p_t[i], m_t[i]);
    end
    wr(ACS_IDX_CTRL, 8'h00);
    $display("test gate done");
    wr(ACS_IDX_COUNT_HI, 8'h00);
    wr(ACS_IDX_COUNT_LO, 8'h00);
    wr(ACS_IDX_CTRL, 8'h31);
    repeat (72) @(posedge pclk);
    wr(ACS_IDX_CTRL, 8'h00);
    rdchk(ACS_IDX_COUNT_LO, 32'h09);
    rdchk(ACS_IDX_COUNT_HI, 32'h00);
    $display("test prescaler done");
    wr(ACS_IDX_CTRL, 8'h08);
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      primary_clk_internal <= p[0];
      repeat (3) @(posedge pclk);
      chk({27'h0, osc_view}, {27'h0, {3{p[0]}}, {2{~p[0]}}});
    end
    wr(ACS_IDX_CTRL, 8'h00);
    $display("test oscillator done");
    complete_run();
  end
endmodule // async_counter_sleep_wake_gate_select_bench
`default_nettype wire
